// ==== indexed_reg_bank.sv ====
`timescale 1ns/1ps

module indexed_reg_bank #(
  parameter int DEPTH = 32,
  parameter logic [DEPTH-1:0] IMPL = '1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic index_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  output logic [7:0] index,
  output logic [7:0] rdata
);

  logic [7:0] next_index;
  logic [7:0] slot [DEPTH];
  genvar g;

  // index holds until the host writes it again
  always_comb
  begin
    next_index = index;
    if (index_we)
      next_index = wdata;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      index <= vga_port_pkg::REG_RESET;
    else
      index <= next_index;
  end

  // ----------------------------------------------------------------
  // storage, one entry per implemented index
  // ----------------------------------------------------------------
  for (g = 0; g < DEPTH; g++)
  begin : entry
    if (IMPL[g])
    begin : impl
      logic [7:0] value;
      logic [7:0] next_value;
      // data port reaches only the entry the index selects
      always_comb
      begin
        next_value = value;
        if (data_we && index == 8'(g))
          next_value = wdata;
      end
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          value <= vga_port_pkg::REG_RESET;
        else
          value <= next_value;
      end
      assign slot[g] = value;
    end
    else
    begin : hole
      assign slot[g] = vga_port_pkg::READ_ZERO;
    end
  end

  // holes and indices past the depth read as zero
  always_comb
  begin
    rdata = vga_port_pkg::READ_ZERO;
    for (int i = 0; i < DEPTH; i++)
      if (index == 8'(i))
        rdata = slot[i];
  end

endmodule : indexed_reg_bank

// ==== legacy_vga_port_decode.sv ====
// What this block does
// - memory accesses decode each port as offset from the programmable base
// - bank registers are reached only through index then data port
// - 3C0h writes alternate index and data; 3C1h reads data, writes reserved
// - 3BAh and 3DAh read input status, write feature control
// - 3C2h reads feature status, writes miscellaneous output
// - 3CCh reads miscellaneous output; writes reserved
// - 3CAh reads feature control; writes reserved
// - 3C7h reads palette state, writes palette read index
// - 3C8h palette write index read/write; 3C9h palette data port
// - 3C6h is a read/write palette pixel mask
// - CRT index/data at 3B4h/3B5h mono and 3D4h/3D5h colour
// - sequencer index at 3C4h, data at 3C5h, both read/write
// - configuration extension index at 3D6h, data at 3D7h
// - sequencer bank implements indices 00h-04h and 07h
// - graphics bank at 3CEh/3CFh implements 00h-08h, 10h, 11h, 18h
// - attribute bank has palette 00h-0Fh and control 10h-14h
// - CRT bank implements 00h-18h plus 22h returning read latch
`timescale 1ns/1ps

module legacy_vga_port_decode (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_mem,
  input wire logic [31:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [31:0] mmio_base_address,
  input wire logic [7:0] input_status_one,
  input wire logic [7:0] feature_read_status,
  input wire logic [7:0] crtc_read_latch,
  input wire logic [7:0] palette_rdata,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] misc_output,
  output logic [7:0] feature_control,
  output logic [7:0] palette_pixel_mask,
  output logic [7:0] palette_read_index,
  output logic [7:0] palette_write_index,
  output logic [7:0] palette_wdata,
  output logic palette_data_we,
  output logic palette_data_re
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [31:0] offset;
  logic [15:0] port;
  logic wr;
  logic rd;

  // io and memory space share one map; memory subtracts the base
  always_comb
  begin
    offset = acc_addr;
    if (acc_mem)
      offset = acc_addr - mmio_base_address;
    port = offset[15:0];
    wr = acc_valid && acc_write
         && offset[31:16] == vga_port_pkg::LEGACY_HIGH_ZERO;
    rd = acc_valid && !acc_write
         && offset[31:16] == vga_port_pkg::LEGACY_HIGH_ZERO;
  end

  // ----------------------------------------------------------------
  // indexed banks
  // ----------------------------------------------------------------
  logic attr_flip;
  logic seq_index_we;
  logic seq_data_we;
  logic gc_index_we;
  logic gc_data_we;
  logic attr_index_we;
  logic attr_data_we;
  logic crtc_index_we;
  logic crtc_data_we;
  logic cfg_index_we;
  logic cfg_data_we;
  logic [7:0] seq_index;
  logic [7:0] seq_rdata;
  logic [7:0] gc_index;
  logic [7:0] gc_rdata;
  logic [7:0] attr_index;
  logic [7:0] attr_rdata;
  logic [7:0] crtc_index;
  logic [7:0] crtc_rdata;
  logic [7:0] cfg_index;
  logic [7:0] cfg_rdata;

  // bank strobes; one shared crt bank sits behind both maps
  assign seq_index_we = wr && port == vga_port_pkg::PORT_SEQ_INDEX;
  assign seq_data_we = wr && port == vga_port_pkg::PORT_SEQ_DATA;
  assign gc_index_we = wr && port == vga_port_pkg::PORT_GC_INDEX;
  assign gc_data_we = wr && port == vga_port_pkg::PORT_GC_DATA;
  assign cfg_index_we = wr && port == vga_port_pkg::PORT_CFG_EXT_INDEX;
  assign cfg_data_we = wr && port == vga_port_pkg::PORT_CFG_EXT_DATA;

  // one port, two meanings, chosen by the flip-flop
  assign attr_index_we = wr && !attr_flip
                         && port == vga_port_pkg::PORT_ATTR_INDEX_WRITE;
  assign attr_data_we = wr && attr_flip
                        && port == vga_port_pkg::PORT_ATTR_INDEX_WRITE;

  assign crtc_index_we = wr
    && (port == vga_port_pkg::PORT_CRTC_INDEX_MONO
        || port == vga_port_pkg::PORT_CRTC_INDEX_COLOR);

  // the read latch slot is read only, so its writes are dropped
  assign crtc_data_we = wr
    && crtc_index != vga_port_pkg::CRTC_READ_LATCH_INDEX
    && (port == vga_port_pkg::PORT_CRTC_DATA_MONO
        || port == vga_port_pkg::PORT_CRTC_DATA_COLOR);

  indexed_reg_bank #(
    .DEPTH(vga_port_pkg::SEQ_DEPTH),
    .IMPL(vga_port_pkg::SEQ_IMPL)
  ) u_seq_bank (
    .mclk(mclk),
    .resetn(resetn),
    .index_we(seq_index_we),
    .data_we(seq_data_we),
    .wdata(acc_wdata),
    .index(seq_index),
    .rdata(seq_rdata)
  );

  indexed_reg_bank #(
    .DEPTH(vga_port_pkg::GC_DEPTH),
    .IMPL(vga_port_pkg::GC_IMPL)
  ) u_gc_bank (
    .mclk(mclk),
    .resetn(resetn),
    .index_we(gc_index_we),
    .data_we(gc_data_we),
    .wdata(acc_wdata),
    .index(gc_index),
    .rdata(gc_rdata)
  );

  indexed_reg_bank #(
    .DEPTH(vga_port_pkg::ATTR_DEPTH),
    .IMPL(vga_port_pkg::ATTR_IMPL)
  ) u_attr_bank (
    .mclk(mclk),
    .resetn(resetn),
    .index_we(attr_index_we),
    .data_we(attr_data_we),
    .wdata(acc_wdata),
    .index(attr_index),
    .rdata(attr_rdata)
  );

  indexed_reg_bank #(
    .DEPTH(vga_port_pkg::CRTC_DEPTH),
    .IMPL(vga_port_pkg::CRTC_IMPL)
  ) u_crtc_bank (
    .mclk(mclk),
    .resetn(resetn),
    .index_we(crtc_index_we),
    .data_we(crtc_data_we),
    .wdata(acc_wdata),
    .index(crtc_index),
    .rdata(crtc_rdata)
  );

  // extension bank is fully populated; its contents are opaque here
  indexed_reg_bank #(
    .DEPTH(vga_port_pkg::CFG_EXT_DEPTH),
    .IMPL('1)
  ) u_cfg_bank (
    .mclk(mclk),
    .resetn(resetn),
    .index_we(cfg_index_we),
    .data_we(cfg_data_we),
    .wdata(acc_wdata),
    .index(cfg_index),
    .rdata(cfg_rdata)
  );

  // ----------------------------------------------------------------
  // direct registers and palette handshake
  // ----------------------------------------------------------------
  logic pal_read_mode;
  logic next_pal_read_mode;
  logic next_attr_flip;
  logic [7:0] next_misc_output;
  logic [7:0] next_feature_control;
  logic [7:0] next_palette_pixel_mask;
  logic [7:0] next_palette_read_index;
  logic [7:0] next_palette_write_index;
  logic [7:0] next_palette_wdata;
  logic next_palette_data_we;
  logic next_palette_data_re;

  // reserved directions fall through every branch untouched
  always_comb
  begin
    next_misc_output = misc_output;
    next_feature_control = feature_control;
    next_palette_pixel_mask = palette_pixel_mask;
    next_palette_read_index = palette_read_index;
    next_palette_write_index = palette_write_index;
    next_palette_wdata = palette_wdata;
    next_pal_read_mode = pal_read_mode;
    next_attr_flip = attr_flip;
    next_palette_data_we = 1'b0;
    next_palette_data_re = 1'b0;
    if (wr)
    begin
      case (port)
        vga_port_pkg::PORT_STATUS_MONO,
        vga_port_pkg::PORT_STATUS_COLOR:
          next_feature_control = acc_wdata;
        vga_port_pkg::PORT_ATTR_INDEX_WRITE:
          next_attr_flip = !attr_flip;
        vga_port_pkg::PORT_FEATURE_MISC:
          next_misc_output = acc_wdata;
        vga_port_pkg::PORT_PIXEL_MASK:
          next_palette_pixel_mask = acc_wdata;
        vga_port_pkg::PORT_PAL_STATE_RINDEX:
        begin
          next_palette_read_index = acc_wdata;
          next_pal_read_mode = 1'b1;
        end
        vga_port_pkg::PORT_PAL_WRITE_INDEX:
        begin
          next_palette_write_index = acc_wdata;
          next_pal_read_mode = 1'b0;
        end
        vga_port_pkg::PORT_PAL_DATA:
        begin
          next_palette_wdata = acc_wdata;
          next_palette_data_we = 1'b1;
        end
        default:
          next_attr_flip = attr_flip;
      endcase
    end
    else if (rd)
    begin
      case (port)
        // a status read puts the attribute port back on index
        vga_port_pkg::PORT_STATUS_MONO,
        vga_port_pkg::PORT_STATUS_COLOR:
          next_attr_flip = 1'b0;
        vga_port_pkg::PORT_PAL_DATA:
          next_palette_data_re = 1'b1;
        default:
          next_attr_flip = attr_flip;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      misc_output <= vga_port_pkg::REG_RESET;
      feature_control <= vga_port_pkg::REG_RESET;
      palette_pixel_mask <= vga_port_pkg::REG_RESET;
      palette_read_index <= vga_port_pkg::REG_RESET;
      palette_write_index <= vga_port_pkg::REG_RESET;
      palette_wdata <= vga_port_pkg::REG_RESET;
      pal_read_mode <= 1'b0;
      attr_flip <= 1'b0;
      palette_data_we <= 1'b0;
      palette_data_re <= 1'b0;
    end
    else
    begin
      misc_output <= next_misc_output;
      feature_control <= next_feature_control;
      palette_pixel_mask <= next_palette_pixel_mask;
      palette_read_index <= next_palette_read_index;
      palette_write_index <= next_palette_write_index;
      palette_wdata <= next_palette_wdata;
      pal_read_mode <= next_pal_read_mode;
      attr_flip <= next_attr_flip;
      palette_data_we <= next_palette_data_we;
      palette_data_re <= next_palette_data_re;
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic [7:0] pal_state;

  // both state bits mirror the last palette index direction
  always_comb
  begin
    pal_state = vga_port_pkg::READ_ZERO;
    pal_state[vga_port_pkg::PAL_STATE_LSB +: vga_port_pkg::PAL_STATE_WIDTH] =
      {vga_port_pkg::PAL_STATE_WIDTH{pal_read_mode}};
  end

  // every read in the legacy window is answered, unmapped ones with zero
  always_comb
  begin
    next_rd_valid = rd;
    next_rd_data = rd_data;
    if (rd)
    begin
      case (port)
        vga_port_pkg::PORT_CRTC_INDEX_MONO,
        vga_port_pkg::PORT_CRTC_INDEX_COLOR:
          next_rd_data = crtc_index;
        vga_port_pkg::PORT_CRTC_DATA_MONO,
        vga_port_pkg::PORT_CRTC_DATA_COLOR:
          if (crtc_index == vga_port_pkg::CRTC_READ_LATCH_INDEX)
            next_rd_data = crtc_read_latch;
          else
            next_rd_data = crtc_rdata;
        vga_port_pkg::PORT_STATUS_MONO,
        vga_port_pkg::PORT_STATUS_COLOR:
          next_rd_data = input_status_one;
        vga_port_pkg::PORT_ATTR_INDEX_WRITE:
          next_rd_data = attr_index;
        vga_port_pkg::PORT_ATTR_DATA_READ:
          next_rd_data = attr_rdata;
        vga_port_pkg::PORT_FEATURE_MISC:
          next_rd_data = feature_read_status;
        vga_port_pkg::PORT_SEQ_INDEX:
          next_rd_data = seq_index;
        vga_port_pkg::PORT_SEQ_DATA:
          next_rd_data = seq_rdata;
        vga_port_pkg::PORT_PIXEL_MASK:
          next_rd_data = palette_pixel_mask;
        vga_port_pkg::PORT_PAL_STATE_RINDEX:
          next_rd_data = pal_state;
        vga_port_pkg::PORT_PAL_WRITE_INDEX:
          next_rd_data = palette_write_index;
        vga_port_pkg::PORT_PAL_DATA:
          next_rd_data = palette_rdata;
        vga_port_pkg::PORT_FEATURE_READBACK:
          next_rd_data = feature_control;
        vga_port_pkg::PORT_MISC_READBACK:
          next_rd_data = misc_output;
        vga_port_pkg::PORT_GC_INDEX:
          next_rd_data = gc_index;
        vga_port_pkg::PORT_GC_DATA:
          next_rd_data = gc_rdata;
        vga_port_pkg::PORT_CFG_EXT_INDEX:
          next_rd_data = cfg_index;
        vga_port_pkg::PORT_CFG_EXT_DATA:
          next_rd_data = cfg_rdata;
        default:
          next_rd_data = vga_port_pkg::READ_ZERO;
      endcase
    end
  end

  // answer lands one edge after the request
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data <= vga_port_pkg::READ_ZERO;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule : legacy_vga_port_decode

// ==== test_legacy_vga_port_decode.sv ====
`timescale 1ns/1ps

module test_legacy_vga_port_decode;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic acc_valid, acc_write, acc_mem;
  logic [31:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [31:0] mmio_base_address = 32'h000B_0000;
  logic [7:0] input_status_one = 8'h96;
  logic [7:0] feature_read_status = 8'h3C;
  logic [7:0] crtc_read_latch = 8'hE1;
  logic [7:0] palette_rdata = 8'h4B;
  logic [7:0] rd_data, misc_output, feature_control, palette_pixel_mask;
  logic [7:0] palette_read_index, palette_write_index, palette_wdata;
  logic rd_valid, palette_data_we, palette_data_re;
  int mismatches = 0;
  int total_checks = 0;

  legacy_vga_port_decode i_legacy_vga_port_decode (.*);
  vga_host_model i_vga_host_model (.*);

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic m, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    i_vga_host_model.xfer(1'b1, m, {16'h0000, a}, d, q, ok);
  endtask : wr

  task rd(input logic m, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    i_vga_host_model.xfer(1'b0, m, {16'h0000, a}, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, e);
  endtask : rd

  // which indices each bank holds: seq, graphics, crt, config extension
  function logic impl(input int b, input int i);
    case (b)
      0: return i <= 4 || i == 7;
      1: return i <= 8 || i == 16 || i == 17 || i == 24;
      2: return i <= 24;
      default: return 1'b1;
    endcase
  endfunction : impl

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(1'b0, 16'h03CC, 8'h00);
    rd(1'b0, 16'h03CA, 8'h00);
    rd(1'b0, 16'h03C8, 8'h00);
  endtask : t_reset

  // direct ports, same effect in io and memory space
  task t_direct(input logic m);
    logic [7:0] v;
    v = m ? 8'h5C : 8'hA3;
    input_status_one = ~v;
    wr(m, 16'h03C2, v);
    chk(misc_output, v);
    rd(m, 16'h03CC, v);
    rd(m, 16'h03C2, feature_read_status);
    wr(m, 16'h03CC, 8'h11);
    wr(m, 16'h03C3, 8'h11);
    rd(m, 16'h03CC, v);
    wr(m, 16'h03BA, ~v);
    rd(m, 16'h03CA, ~v);
    wr(m, 16'h03DA, v);
    wr(m, 16'h03CA, 8'h33);
    rd(m, 16'h03CA, v);
    chk(feature_control, v);
    rd(m, 16'h03BA, ~v);
    rd(m, 16'h03DA, ~v);
    rd(m, 16'h03B0, 8'h00);
  endtask : t_direct

  task t_palette;
    wr(1'b0, 16'h03C6, 8'h5A);
    rd(1'b0, 16'h03C6, 8'h5A);
    chk(palette_pixel_mask, 8'h5A);
    wr(1'b0, 16'h03C7, 8'h12);
    chk(palette_read_index, 8'h12);
    rd(1'b0, 16'h03C7, 8'h03);
    wr(1'b0, 16'h03C8, 8'h34);
    rd(1'b0, 16'h03C8, 8'h34);
    chk(palette_write_index, 8'h34);
    rd(1'b0, 16'h03C7, 8'h00);
    wr(1'b0, 16'h03C9, 8'h9E);
    chk({palette_data_we, palette_wdata[6:0]}, 8'h9E);
    chk(palette_wdata, 8'h9E);
    rd(1'b0, 16'h03C9, palette_rdata);
    chk({7'h00, palette_data_re}, 8'h01);
  endtask : t_palette

  // crt written through mono ports and read back through colour ports
  task t_banks;
    logic [15:0] wi[4];
    logic [15:0] ri[4];
    logic [7:0] e;
    wi = '{16'h03C4, 16'h03CE, 16'h03B4, 16'h03D6};
    ri = '{16'h03C4, 16'h03CE, 16'h03D4, 16'h03D6};
    for (int b = 0; b < 4; b++)
    begin
      for (int i = 0; i < 40; i++)
      begin
        wr(1'b0, wi[b], 8'(i));
        wr(1'b0, wi[b] + 16'h0001, 8'(i) ^ 8'hC3 ^ 8'(b));
      end
      for (int i = 0; i < 40; i++)
      begin
        e = impl(b, i) ? 8'(i) ^ 8'hC3 ^ 8'(b) : 8'h00;
        if (b == 2 && i == 34)
          e = crtc_read_latch;
        wr(1'b0, ri[b], 8'(i));
        rd(1'b0, ri[b], 8'(i));
        rd(1'b0, ri[b] + 16'h0001, e);
      end
    end
  endtask : t_banks

  task t_attr;
    rd(1'b0, 16'h03DA, input_status_one);
    for (int i = 0; i < 24; i++)
    begin
      wr(1'b0, 16'h03C0, 8'(i));
      wr(1'b0, 16'h03C0, 8'(i) ^ 8'h69);
    end
    for (int i = 0; i < 24; i++)
    begin
      wr(1'b0, 16'h03C0, 8'h1F);
      rd(1'b0, 16'h03DA, input_status_one);
      wr(1'b0, 16'h03C0, 8'(i));
      wr(1'b0, 16'h03C1, 8'hFF);
      rd(1'b0, 16'h03C0, 8'(i));
      rd(1'b0, 16'h03C1, i <= 20 ? 8'(i) ^ 8'h69 : 8'h00);
      rd(1'b0, 16'h03DA, input_status_one);
    end
  endtask : t_attr

  // addresses outside the legacy window are not answered
  task t_refused;
    logic [7:0] q;
    logic ok;
    wr(1'b0, 16'h03C2, 8'h6E);
    i_vga_host_model.xfer(1'b1, 1'b1, 32'h0100_03C2, 8'h00, q, ok);
    i_vga_host_model.xfer(1'b1, 1'b0, 32'h000B_03C2, 8'h00, q, ok);
    i_vga_host_model.xfer(1'b0, 1'b0, 32'h000B_03CC, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h00);
    rd(1'b1, 16'h03CC, 8'h6E);
  endtask : t_refused

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_reset;
    t_direct(1'b0);
    t_direct(1'b1);
    t_palette;
    t_banks;
    t_attr;
    t_refused;
    end_of_test;
  end

  // watchdog, far beyond the few thousand cycles the run needs
  initial
  begin
    #500000;
    mismatches++;
    end_of_test;
  end
endmodule : test_legacy_vga_port_decode

bind legacy_vga_port_decode vga_decode_assertions i_vga_decode_assertions (.*);

// ==== vga_decode_assertions.sv ====
`timescale 1ns/1ps

module vga_decode_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_mem,
  input wire logic [31:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [31:0] mmio_base_address,
  input wire logic [7:0] input_status_one,
  input wire logic [7:0] feature_read_status,
  input wire logic [7:0] crtc_read_latch,
  input wire logic [7:0] palette_rdata,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] misc_output,
  input wire logic [7:0] feature_control,
  input wire logic [7:0] palette_pixel_mask,
  input wire logic [7:0] palette_read_index,
  input wire logic [7:0] palette_write_index,
  input wire logic [7:0] palette_wdata,
  input wire logic palette_data_we,
  input wire logic palette_data_re
);
  // ----------------------------------------------------------------
  // decoded port of this cycle's access
  // ----------------------------------------------------------------
  logic [31:0] off;
  logic [15:0] wp;
  logic [15:0] rp;

  // ffff matches no listed port, so it stands for no access
  assign off = acc_mem ? acc_addr - mmio_base_address : acc_addr;
  assign wp = (acc_valid && acc_write && off[31:16] == 16'h0000) ? off[15:0] : 16'hFFFF;
  assign rp = (acc_valid && !acc_write && off[31:16] == 16'h0000) ? off[15:0] : 16'hFFFF;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // answers and register effects
  // ----------------------------------------------------------------
  sequence s_zero_answer;
    rd_valid && rd_data == 8'h00;
  endsequence
  sequence s_pal_strobe;
    palette_data_we && palette_wdata == $past(acc_wdata);
  endsequence

  a_read_answer: assert property (rp != 16'hFFFF |=> rd_valid)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (rd_valid |-> $past(rp) != 16'hFFFF)
    else $error("answer without a read");
  a_refused_silent: assert property (acc_valid && off[31:16] != 16'h0000
    |=> !rd_valid && $stable(misc_output) && $stable(feature_control))
    else $error("non-legacy access had an effect");
  a_status_read: assert property (rp inside {16'h03BA, 16'h03DA}
    |=> rd_data == $past(input_status_one))
    else $error("status read wrong");
  a_feature_write: assert property (wp inside {16'h03BA, 16'h03DA}
    |=> feature_control == $past(acc_wdata))
    else $error("feature control not loaded");
  a_feature_read: assert property (rp == 16'h03C2 |=> rd_data == $past(feature_read_status))
    else $error("feature status read wrong");
  a_misc_write: assert property (wp == 16'h03C2 |=> misc_output == $past(acc_wdata))
    else $error("misc output not loaded");
  a_misc_readback: assert property (rp == 16'h03CC |=> rd_data == $past(misc_output))
    else $error("misc readback wrong");
  a_feature_readback: assert property (rp == 16'h03CA |=> rd_data == $past(feature_control))
    else $error("feature readback wrong");
  a_reserved_write: assert property (wp inside {16'h03C1, 16'h03CA, 16'h03CC}
    |=> $stable(misc_output) && $stable(feature_control))
    else $error("reserved write had an effect");
  a_reserved_read: assert property (rp inside {16'h03B0, 16'h03C3, 16'h03DB}
    |=> s_zero_answer)
    else $error("reserved read not zero");
  a_pal_write: assert property (wp == 16'h03C9 |=> s_pal_strobe)
    else $error("palette write strobe wrong");
  a_pal_read: assert property (rp == 16'h03C9
    |=> palette_data_re && rd_data == $past(palette_rdata))
    else $error("palette read wrong");
  a_pal_index: assert property (wp == 16'h03C7 |=> palette_read_index == $past(acc_wdata))
    else $error("palette read index not loaded");
endmodule : vga_decode_assertions

// ==== vga_host_model.sv ====
`timescale 1ns/1ps

module vga_host_model (
  input wire logic mclk,
  input wire logic [31:0] mmio_base_address,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_mem,
  output logic [31:0] acc_addr,
  output logic [7:0] acc_wdata
);
  // idle bus at time zero
  initial
  begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_mem = 1'b0;
    acc_addr = 32'h0000_0000;
    acc_wdata = 8'h00;
  end

  // one access held for one edge; memory space adds the base
  task xfer(input logic w, input logic m, input logic [31:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic ok);
    @(posedge mclk);
    #1;
    acc_valid = 1'b1;
    acc_write = w;
    acc_mem = m;
    acc_addr = m ? mmio_base_address + a : a;
    acc_wdata = d;
    @(posedge mclk);
    #1;
    acc_valid = 1'b0;
    // released lines show garbage, never the old value
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
    q = rd_data;
    ok = rd_valid;
  endtask : xfer
endmodule : vga_host_model

// ==== vga_port_pkg.sv ====
package vga_port_pkg;

  // ----------------------------------------------------------------
  // direct port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_CRTC_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] PORT_CRTC_DATA_MONO = 16'h03B5;
  localparam logic [15:0] PORT_STATUS_MONO = 16'h03BA;
  localparam logic [15:0] PORT_ATTR_INDEX_WRITE = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_DATA_READ = 16'h03C1;
  localparam logic [15:0] PORT_FEATURE_MISC = 16'h03C2;
  localparam logic [15:0] PORT_SEQ_INDEX = 16'h03C4;
  localparam logic [15:0] PORT_SEQ_DATA = 16'h03C5;
  localparam logic [15:0] PORT_PIXEL_MASK = 16'h03C6;
  localparam logic [15:0] PORT_PAL_STATE_RINDEX = 16'h03C7;
  localparam logic [15:0] PORT_PAL_WRITE_INDEX = 16'h03C8;
  localparam logic [15:0] PORT_PAL_DATA = 16'h03C9;
  localparam logic [15:0] PORT_FEATURE_READBACK = 16'h03CA;
  localparam logic [15:0] PORT_MISC_READBACK = 16'h03CC;
  localparam logic [15:0] PORT_GC_INDEX = 16'h03CE;
  localparam logic [15:0] PORT_GC_DATA = 16'h03CF;
  localparam logic [15:0] PORT_CRTC_INDEX_COLOR = 16'h03D4;
  localparam logic [15:0] PORT_CRTC_DATA_COLOR = 16'h03D5;
  localparam logic [15:0] PORT_CFG_EXT_INDEX = 16'h03D6;
  localparam logic [15:0] PORT_CFG_EXT_DATA = 16'h03D7;
  localparam logic [15:0] PORT_STATUS_COLOR = 16'h03DA;

  // ----------------------------------------------------------------
  // indexed banks: depth and implemented-index masks
  // ----------------------------------------------------------------
  localparam int SEQ_DEPTH = 8;
  localparam logic [7:0] SEQ_IMPL = 8'h9F;
  localparam int GC_DEPTH = 32;
  localparam logic [31:0] GC_IMPL = 32'h010301FF;
  localparam int ATTR_DEPTH = 32;
  localparam logic [31:0] ATTR_IMPL = 32'h001FFFFF;
  localparam int CRTC_DEPTH = 64;
  localparam logic [63:0] CRTC_IMPL = 64'h00000000_01FFFFFF;
  localparam logic [7:0] CRTC_READ_LATCH_INDEX = 8'h22;
  localparam int CFG_EXT_DEPTH = 256;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [15:0] LEGACY_HIGH_ZERO = 16'h0000;
  localparam int PAL_STATE_LSB = 0;
  localparam int PAL_STATE_WIDTH = 2;

endpackage : vga_port_pkg
